// ===== pdfs_defines.svh
`ifndef PDFS_DEFINES_SVH
`define PDFS_DEFINES_SVH
// timing
`define PDFS_CLK_NS 50
`define PDFS_DT_STEP_NS 250
`define PDFS_DT_STEP_CYC ((`PDFS_DT_STEP_NS + `PDFS_CLK_NS - 1) / `PDFS_CLK_NS)
`define PDFS_BLANK_STEP_NS 1000
`define PDFS_BLANK_STEP_CYC \
	((`PDFS_BLANK_STEP_NS + `PDFS_CLK_NS - 1) / `PDFS_CLK_NS)
// configuration byte map
`define PDFS_CFG_BYTES 6
`define PDFS_ADDR_TIMING 3'h2
`define PDFS_ADDR_GAIN 3'h3
`define PDFS_ADDR_PROT 3'h4
`define PDFS_ADDR_IFACE 3'h5
`define PDFS_DEF_B0 8'h00
`define PDFS_DEF_B1 8'h00
`define PDFS_DEF_B2 8'h7c
`define PDFS_DEF_B3 8'ha6
`define PDFS_DEF_B4 8'he0
`define PDFS_DEF_B5 8'hc0
// field positions
`define PDFS_F_DT 7:5
`define PDFS_F_THR 4:2
`define PDFS_F_BREF 1
`define PDFS_F_BLANK 7:6
`define PDFS_F_RATE 5
`define PDFS_F_GAIN 3:1
`define PDFS_F_ROVBF 7
`define PDFS_F_DSBF 6
`define PDFS_F_DSCMP 5
`define PDFS_F_GUV 4
`define PDFS_F_PUMP 2
`define PDFS_F_SPIEN 7
// synchronised pin vector
`define PDFS_PIN_W 18
`define PDFS_P_EN 0
`define PDFS_P_VCC 1
`define PDFS_P_MOV 2
`define PDFS_P_ROV 3
`define PDFS_P_GUV 4
`define PDFS_P_ACK 5
`define PDFS_P_DS 11:6
`define PDFS_P_HI 14:12
`define PDFS_P_LO 17:15
`define PDFS_P_HI0 12
`define PDFS_P_LO0 15
// fault latch slots and report codes
`define PDFS_FLT_N 5
`define PDFS_FLT_ROV 0
`define PDFS_FLT_GUV 1
`define PDFS_FLT_MOV 2
`define PDFS_FLT_EEP 3
`define PDFS_FLT_DS 4
`define PDFS_CODE_NONE 4'h0
`define PDFS_CODE_ROV 4'h1
`define PDFS_CODE_GUV 4'h3
`define PDFS_CODE_MOV 4'h7
`define PDFS_CODE_EEP 4'h9
`define PDFS_CODE_DS 4'ha
`define PDFS_CODE_EOF 4'hb
`endif

// ===== pdfs_pkg.sv
package pdfs_pkg;
	typedef enum logic [1:0] {LD_IDLE, LD_COPY, LD_DONE} pdfs_load_t;
	typedef logic [7:0] pdfs_byte_t;
	typedef logic [12:0] pdfs_cw_t;
	typedef logic [3:0] pdfs_code_t;

	// hamming positions 1..12 with an overall parity in bit 0
	function automatic pdfs_cw_t pdfs_encode(input pdfs_byte_t d);
		logic [12:1] w;
		int k;
		w = '0;
		k = 0;
		for (int i = 1; i <= 12; i++) begin
			if ((i & (i - 1)) != 0) begin
				w[i] = d[k];
				k++;
			end
		end
		for (int i = 1; i <= 12; i++) begin
			for (int b = 0; b < 4; b++) begin
				if (i[b] && i != (1 << b))
					w[1 << b] = w[1 << b] ^ w[i];
			end
		end
		return {w, ^w};
	endfunction : pdfs_encode
endpackage : pdfs_pkg

// ===== pdfs_secded_dec.sv
`timescale 1ns/100ps
module pdfs_secded_dec (
	input wire pdfs_pkg::pdfs_cw_t cw, // stored code word
	output pdfs_pkg::pdfs_byte_t data, // corrected byte
	output logic corrected, // one bit was repaired
	output logic double_err // two bits bad, data unusable
);
	import pdfs_pkg::*;
	logic [3:0] syn;
	logic [12:1] fixed;
	int k;

	// syndrome points at the bad position; overall parity tells 1 from 2
	always_comb begin
		syn = 4'h0;
		k = 0;
		for (int i = 1; i <= 12; i++) begin
			if (cw[i])
				syn = syn ^ 4'(i);
		end
		fixed = cw[12:1];
		corrected = (^cw) && (syn <= 4'hc);
		double_err = ((syn != 4'h0) && !(^cw)) || (syn > 4'hc);
		if (corrected && syn != 4'h0)
			fixed[syn] = ~fixed[syn];
		data = 8'h00;
		for (int i = 1; i <= 12; i++) begin
			if ((i & (i - 1)) != 0) begin
				data[k] = fixed[i];
				k++;
			end
		end
	end
endmodule : pdfs_secded_dec

// ===== pdfs_dead_time.sv
`timescale 1ns/100ps
module pdfs_dead_time #(
	parameter int CW = 8
) (
	input wire logic clk, // core clock
	input wire logic rstn, // sync reset, active low
	input wire logic force_off, // hold both gates low
	input wire logic hi_req, // high-side request
	input wire logic lo_req, // low-side request
	input wire logic [CW-1:0] dt_cycles, // gap length in cycles
	output logic hi_out, // high-side gate
	output logic lo_out // low-side gate
);
	logic [CW-1:0] cnt_reg;
	logic hi_next;
	logic lo_next;

	if (CW < 6) begin : g_chk
		$error("dead time counter too narrow");
	end

	// a side may only rise after the other is low and the gap has run out
	always_comb begin
		hi_next = !force_off && hi_req && !lo_req &&
			(hi_out || (!lo_out && cnt_reg == '0));
		lo_next = !force_off && lo_req && !hi_req &&
			(lo_out || (!hi_out && cnt_reg == '0));
	end

	// gap restarts whenever a gate falls
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_reg <= '0;
		end else if ((hi_out && !hi_next) || (lo_out && !lo_next)) begin
			cnt_reg <= dt_cycles;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hi_out <= 1'b0;
			lo_out <= 1'b0;
		end else begin
			hi_out <= hi_next;
			lo_out <= lo_next;
		end
	end
endmodule : pdfs_dead_time

// ===== pdfs_shutdown.sv
`timescale 1ns/100ps
`include "pdfs_defines.svh"
// What this block does
// RULE_01 - motor supply overvoltage always disables gates, no setting masks it
// RULE_02 - a protection disable pulls every gate output low
// RULE_03 - comparator enable 0: drain-source events ignored, no report
// RULE_04 - comparator 1, shutdown 0: report drain-source fault, keep running
// RULE_05 - comparator 1, shutdown 1: report drain-source fault and disable
// RULE_06 - regulator overvoltage always reported; disables only if its bit is 1
// RULE_07 - protection disable holds until end-of-frame is acknowledged
// RULE_08 - low logic supply disables gates, release when it returns high
// RULE_09 - low enable disables gates, release when enable is high
// RULE_10 - stored configuration corrects single and detects double bit errors
// RULE_11 - 3-bit gap field sets dead time, default 011
// RULE_12 - 3-bit threshold field selects detection level, default 111
// RULE_13 - 2-bit blanking field masks monitoring after turn-in, default 10
// RULE_14 - 3-bit gain field selects sense gain, default 011
// RULE_15 - boost reference bit: 0 ground, 1 supply, default 0
// RULE_16 - serial enable default 1; in serial mode only 1 to 0
// RULE_17 - gate undervoltage comparator enable bit, default 0
// RULE_18 - fault rate bit: 1 fast default, 0 slow
// RULE_19 - boost pump enable bit, default 0
// RULE_20 - drain-source comparator enable bit, default 1
// RULE_21 - acknowledging end-of-frame clears all latched faults
// RULE_22 - gates blocked until stored configuration copied after reset/serial
// RULE_23 - drain-source fault is OR of six comparator outputs
// RULE_24 - reserved bits kept as programmed, never used by logic
module pdfs_shutdown (
	input wire logic clk, // core clock, 20 MHz
	input wire logic rstn, // sync reset, active low
	input wire logic enable_pin, // host enable pin
	input wire logic vcc_ok_pin, // logic supply good
	input wire logic motor_supply_overvolt_flag, // comparator
	input wire logic regulator_overvolt_flag, // comparator
	input wire logic gate_uv_raw, // gate undervoltage comparator
	input wire logic [5:0] ds_comp_raw, // per-transistor comparators
	input wire logic fault_ack_pin, // host holds fault line low
	input wire logic [2:0] gate_hi_req, // high-side requests
	input wire logic [2:0] gate_lo_req, // low-side requests
	input wire logic serial_mode, // serial programming active
	input wire logic cfg_wr, // config write strobe
	input wire logic [2:0] cfg_addr, // config byte address
	input wire pdfs_pkg::pdfs_byte_t cfg_wdata, // config write byte
	output pdfs_pkg::pdfs_byte_t cfg_rdata, // config read byte
	output logic [2:0] gate_hi_out, // high-side gates
	output logic [2:0] gate_lo_out, // low-side gates
	output logic gates_off, // all gates forced low
	output logic fault_active, // fault line in report mode
	output pdfs_pkg::pdfs_code_t fault_code, // code being reported
	output logic [2:0] dead_time_select, // gap field
	output logic [2:0] ds_threshold_select, // detection level
	output logic [2:0] sense_gain_select, // amplifier gain
	output logic boost_reference_select, // 0 ground, 1 supply
	output logic gate_uv_comparator_enable, // comparator power
	output logic boost_pump_enable, // pump power
	output logic fault_rate_fast, // report rate select
	output logic serial_port_enable, // serial block allowed
	output logic config_ready // working copy is valid
);
	import pdfs_pkg::*;

	localparam pdfs_byte_t DEF [`PDFS_CFG_BYTES] = '{`PDFS_DEF_B0,
		`PDFS_DEF_B1, `PDFS_DEF_B2, `PDFS_DEF_B3, `PDFS_DEF_B4,
		`PDFS_DEF_B5};
	localparam pdfs_code_t CODES [`PDFS_FLT_N] = '{`PDFS_CODE_ROV,
		`PDFS_CODE_GUV, `PDFS_CODE_MOV, `PDFS_CODE_EEP, `PDFS_CODE_DS};
	localparam logic [2:0] LAST_ADDR = 3'(`PDFS_CFG_BYTES - 1);
	localparam logic [7:0] DT_STEP = 8'(`PDFS_DT_STEP_CYC);
	localparam logic [7:0] BLANK_STEP = 8'(`PDFS_BLANK_STEP_CYC);

	logic [`PDFS_PIN_W-1:0] pins;
	logic [`PDFS_PIN_W-1:0] s1_reg;
	logic [`PDFS_PIN_W-1:0] s2_reg;
	logic [`PDFS_PIN_W-1:0] s3_reg;
	logic [`PDFS_PIN_W-1:0] pin_reg;
	pdfs_cw_t store_reg [`PDFS_CFG_BYTES];
	pdfs_byte_t work_reg [`PDFS_CFG_BYTES];
	pdfs_load_t ld_reg;
	logic [2:0] ld_idx_reg;
	pdfs_byte_t timing_byte, gain_byte, prot_byte, iface_byte;
	logic [2:0] dec_addr;
	pdfs_byte_t dec_data;
	logic dec_dbl;
	logic wr_ok;
	pdfs_byte_t wr_byte;
	logic eep_evt;
	logic ack_q_reg;
	logic ack_evt;
	logic eof_ack;
	logic [`PDFS_FLT_N-1:0] flt_set;
	logic [`PDFS_FLT_N-1:0] latched_reg;
	logic [`PDFS_FLT_N-1:0] sent_reg;
	logic [`PDFS_FLT_N-1:0] sent_next;
	logic [2:0] cur_idx;
	logic cur_any;
	logic [2:0] idx_reg;
	pdfs_code_t code_next;
	logic prot_set;
	logic prot_off_reg;
	logic off_next;
	logic ds_any;
	logic ds_acc;
	logic [7:0] blank_reg;
	logic [7:0] blank_cyc;
	logic [7:0] dt_cyc;
	logic [5:0] outs_q_reg;
	logic ds_cmp_en;
	logic ds_bf_en;
	logic reg_ov_shutdown_enable;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	assign pins = {gate_lo_req, gate_hi_req, ds_comp_raw, fault_ack_pin,
		gate_uv_raw, regulator_overvolt_flag, motor_supply_overvolt_flag,
		vcc_ok_pin, enable_pin};

	// three stages; a bit moves only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			pin_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) |
				(pin_reg & (s2_reg ^ s3_reg));
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration storage and working copy
	assign wr_ok = serial_mode && serial_port_enable && cfg_wr &&
		cfg_addr <= LAST_ADDR;
	assign dec_addr = (ld_reg == LD_COPY) ? ld_idx_reg : cfg_addr;

	// the enable bit may only fall while in serial mode
	always_comb begin
		wr_byte = cfg_wdata;
		if (cfg_addr == `PDFS_ADDR_IFACE)
			wr_byte[`PDFS_F_SPIEN] = cfg_wdata[`PDFS_F_SPIEN] &&
				work_reg[`PDFS_CFG_BYTES-1][`PDFS_F_SPIEN]; // RULE_16
	end

	pdfs_secded_dec u_dec (
		.cw(store_reg[dec_addr]),
		.data(dec_data),
		.corrected(),
		.double_err(dec_dbl)
	);

	// words are stored with check bits; reserved bits kept as written
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < `PDFS_CFG_BYTES; i++)
				store_reg[i] <= pdfs_encode(DEF[i]);
		end else if (wr_ok) begin
			store_reg[cfg_addr] <= pdfs_encode(wr_byte); // RULE_10 RULE_24
		end
	end

	// read-back gives the corrected byte; unmapped or locked reads zero
	always_ff @(posedge clk) begin
		if (!rstn)
			cfg_rdata <= 8'h00;
		else if (serial_mode && serial_port_enable && cfg_addr <= LAST_ADDR)
			cfg_rdata <= dec_data; // RULE_10
		else
			cfg_rdata <= 8'h00;
	end

	// copier: runs after reset and after leaving serial mode
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ld_reg <= LD_COPY;
			ld_idx_reg <= 3'h0;
		end else begin
			case (ld_reg)
				LD_IDLE: begin
					if (!serial_mode)
						ld_reg <= LD_COPY; // RULE_22
					ld_idx_reg <= 3'h0;
				end
				LD_COPY: begin
					ld_idx_reg <= ld_idx_reg + 3'h1;
					if (ld_idx_reg == LAST_ADDR)
						ld_reg <= LD_DONE;
				end
				LD_DONE: begin
					if (serial_mode)
						ld_reg <= LD_IDLE;
				end
				default: ld_reg <= LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < `PDFS_CFG_BYTES; i++)
				work_reg[i] <= DEF[i];
		end else if (ld_reg == LD_COPY) begin
			work_reg[ld_idx_reg] <= dec_data; // RULE_10
		end
	end
	assign eep_evt = (ld_reg == LD_COPY) && dec_dbl;
	assign config_ready = (ld_reg == LD_DONE);

	// field decode straight from the working bytes
	assign timing_byte = work_reg[`PDFS_ADDR_TIMING];
	assign gain_byte = work_reg[`PDFS_ADDR_GAIN];
	assign prot_byte = work_reg[`PDFS_ADDR_PROT];
	assign iface_byte = work_reg[`PDFS_ADDR_IFACE];
	assign dead_time_select = timing_byte[`PDFS_F_DT]; // RULE_11
	assign ds_threshold_select = timing_byte[`PDFS_F_THR]; // RULE_12
	assign boost_reference_select = timing_byte[`PDFS_F_BREF]; // RULE_15
	assign fault_rate_fast = gain_byte[`PDFS_F_RATE]; // RULE_18
	assign sense_gain_select = gain_byte[`PDFS_F_GAIN]; // RULE_14
	assign reg_ov_shutdown_enable = prot_byte[`PDFS_F_ROVBF];
	assign ds_bf_en = prot_byte[`PDFS_F_DSBF];
	assign ds_cmp_en = prot_byte[`PDFS_F_DSCMP]; // RULE_20
	assign gate_uv_comparator_enable = prot_byte[`PDFS_F_GUV]; // RULE_17
	assign boost_pump_enable = prot_byte[`PDFS_F_PUMP]; // RULE_19
	assign serial_port_enable = iface_byte[`PDFS_F_SPIEN]; // RULE_16

	////////////////////////////////////////////////////////////////////
	// drain-source monitor with blanking
	assign ds_any = |pin_reg[`PDFS_P_DS]; // RULE_23
	assign blank_cyc = 8'(({6'h0, gain_byte[`PDFS_F_BLANK]} + 8'h1) *
		BLANK_STEP); // RULE_13
	assign dt_cyc = 8'(({5'h0, timing_byte[`PDFS_F_DT]} + 8'h1) * DT_STEP);
	assign ds_acc = ds_cmp_en && ds_any && blank_reg == 8'h0; // RULE_03

	// any gate rising restarts the blanking window
	always_ff @(posedge clk) begin
		if (!rstn) begin
			outs_q_reg <= 6'h00;
			blank_reg <= 8'h00;
		end else begin
			outs_q_reg <= {gate_lo_out, gate_hi_out};
			if (|({gate_lo_out, gate_hi_out} & ~outs_q_reg))
				blank_reg <= blank_cyc; // RULE_13
			else if (blank_reg != 8'h0)
				blank_reg <= blank_reg - 8'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// fault latches and report sequencing
	always_comb begin
		flt_set = '0;
		flt_set[`PDFS_FLT_ROV] = pin_reg[`PDFS_P_ROV]; // RULE_06
		flt_set[`PDFS_FLT_GUV] = pin_reg[`PDFS_P_GUV] &&
			gate_uv_comparator_enable;
		flt_set[`PDFS_FLT_MOV] = pin_reg[`PDFS_P_MOV];
		flt_set[`PDFS_FLT_EEP] = eep_evt;
		flt_set[`PDFS_FLT_DS] = ds_acc; // RULE_04 RULE_05
	end

	// ack counts at the host's falling edge, only while reporting
	assign ack_evt = pin_reg[`PDFS_P_ACK] && !ack_q_reg && fault_active;
	assign eof_ack = ack_evt && fault_code == `PDFS_CODE_EOF;

	// highest untransmitted fault goes next; none left means end-of-frame
	always_comb begin
		cur_idx = 3'h0;
		cur_any = 1'b0;
		for (int i = 0; i < `PDFS_FLT_N; i++) begin
			if (latched_reg[i] && !sent_next[i] && !eof_ack) begin
				cur_idx = 3'(i);
				cur_any = 1'b1;
			end
		end
		if (cur_any)
			code_next = CODES[cur_idx];
		else if (|latched_reg && !eof_ack)
			code_next = `PDFS_CODE_EOF;
		else
			code_next = `PDFS_CODE_NONE;
	end

	always_comb begin
		sent_next = sent_reg;
		if (eof_ack)
			sent_next = '0;
		else if (ack_evt)
			sent_next[idx_reg] = 1'b1;
	end

	// a fresh fault in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			latched_reg <= '0;
			sent_reg <= '0;
			ack_q_reg <= 1'b0;
		end else begin
			ack_q_reg <= pin_reg[`PDFS_P_ACK];
			latched_reg <= (eof_ack ? '0 : latched_reg) | flt_set; // RULE_21
			sent_reg <= sent_next & ~flt_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fault_code <= `PDFS_CODE_NONE;
			idx_reg <= 3'h0;
			fault_active <= 1'b0;
		end else begin
			fault_code <= code_next;
			idx_reg <= cur_idx;
			fault_active <= code_next != `PDFS_CODE_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// shutdown decision
	assign prot_set = pin_reg[`PDFS_P_MOV] || // RULE_01
		(ds_acc && ds_bf_en) || // RULE_05
		(pin_reg[`PDFS_P_ROV] && reg_ov_shutdown_enable); // RULE_06

	// protection holds past supply and enable, only end-of-frame frees it
	always_ff @(posedge clk) begin
		if (!rstn)
			prot_off_reg <= 1'b0;
		else
			prot_off_reg <= prot_set || (prot_off_reg && !eof_ack); // RULE_07
	end

	assign off_next = prot_off_reg ||
		!pin_reg[`PDFS_P_VCC] || // RULE_08
		!pin_reg[`PDFS_P_EN] || // RULE_09
		ld_reg != LD_DONE || serial_mode; // RULE_22

	// registered so every phase sees the same forced-off cycle
	always_ff @(posedge clk) begin
		if (!rstn)
			gates_off <= 1'b1;
		else
			gates_off <= off_next;
	end

	////////////////////////////////////////////////////////////////////
	// per-phase gate stages
	for (genvar p = 0; p < 3; p++) begin : g_phase
		pdfs_dead_time #(.CW(8)) u_dt (
			.clk(clk),
			.rstn(rstn),
			.force_off(gates_off), // RULE_02
			.hi_req(pin_reg[`PDFS_P_HI0 + p]),
			.lo_req(pin_reg[`PDFS_P_LO0 + p]),
			.dt_cycles(dt_cyc), // RULE_11
			.hi_out(gate_hi_out[p]),
			.lo_out(gate_lo_out[p])
		);
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_eof_ack;
		eof_ack && flt_set == '0;
	endsequence

	a_mov_shuts_down: assert property ( // RULE_01
		pin_reg[`PDFS_P_MOV] |=> prot_off_reg ##1 gates_off)
		else $error("overvoltage did not force gates off");
	a_gates_pulled_low: assert property ( // RULE_02
		gates_off |=> gate_hi_out == 3'h0 && gate_lo_out == 3'h0)
		else $error("gate output high while disabled");
	a_ds_ignored: assert property ( // RULE_03
		!ds_cmp_en && !latched_reg[`PDFS_FLT_DS] |=> !latched_reg[`PDFS_FLT_DS])
		else $error("drain-source fault latched with comparator off");
	a_ds_report_only: assert property ( // RULE_04
		ds_acc && !ds_bf_en && !prot_off_reg && !pin_reg[`PDFS_P_MOV] &&
		!pin_reg[`PDFS_P_ROV] |=> latched_reg[`PDFS_FLT_DS] && !prot_off_reg)
		else $error("report-only drain-source fault misbehaved");
	a_ds_shutdown: assert property ( // RULE_05
		ds_acc && ds_bf_en |=> latched_reg[`PDFS_FLT_DS] && prot_off_reg)
		else $error("drain-source fault did not disable");
	a_rov_reported: assert property ( // RULE_06
		pin_reg[`PDFS_P_ROV] |=> latched_reg[`PDFS_FLT_ROV] &&
		(prot_off_reg || !$past(reg_ov_shutdown_enable)))
		else $error("regulator overvoltage not handled");
	a_prot_holds: assert property ( // RULE_07
		prot_off_reg && !eof_ack |=> prot_off_reg)
		else $error("protection released without end-of-frame");
	a_vcc_blocks: assert property ( // RULE_08
		!pin_reg[`PDFS_P_VCC] |=> gates_off)
		else $error("gates not off with supply low");
	a_enable_blocks: assert property ( // RULE_09
		!pin_reg[`PDFS_P_EN] |=> gates_off)
		else $error("gates not off with enable low");
	a_eof_clears: assert property ( // RULE_21
		s_eof_ack |=> latched_reg == '0 && !prot_off_reg)
		else $error("end-of-frame did not clear faults");
	a_load_blocks: assert property ( // RULE_22
		ld_reg != LD_DONE |=> gates_off)
		else $error("gates released before copy finished");
	a_spien_sticky: assert property ( // RULE_16
		!serial_port_enable && !serial_mode |=> !serial_port_enable ||
		$past(ld_reg) == LD_COPY)
		else $error("serial enable rose without reload");
endmodule : pdfs_shutdown

// ===== pdfs_host_model.sv
`timescale 1ns/100ps
// host side: drives the enable pin and acknowledges fault reports
module pdfs_host_model (
	input wire logic clk, // core clock
	input wire logic en_req, // bench asks the bridge to run
	input wire logic ack_en, // host may acknowledge
	input wire logic slow, // answer late instead of promptly
	input wire logic fault_active, // fault line is reporting
	output logic enable_pin, // to device enable
	output logic fault_ack_pin // high while host holds the line low
);
	int cnt = 0;
	////////////////////////////////////////////////////////////////////////
	// enable follows the bench request directly, so no edge race
	assign enable_pin = en_req;
	// line held low for 8 cycles, longer than one report period, then
	// 8 quiet cycles so the next report code is seen before acking again
	always @(negedge clk) begin
		if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (ack_en && fault_active) begin
			cnt <= slow ? 60 : 24;
		end
		fault_ack_pin <= (cnt > 8) && (cnt <= 16);
	end
endmodule : pdfs_host_model

// ===== test_pdfs_shutdown.sv
`timescale 1ns/100ps
// self-checking bench for the fault shutdown block
module test_pdfs_shutdown;
	import pdfs_pkg::*;
	typedef struct packed {
		logic [7:0] cfg4;
		logic en, vcc, mov, rov, guv;
		logic [5:0] ds;
		logic off;
		logic [3:0] code;
	} pdfs_row_t;
	logic clk, rstn, en_req, ack_en, slow, enable_pin, fault_ack_pin;
	logic vcc_ok, mov, rov, guv, serial_mode, cfg_wr, gates_off;
	logic fault_active, bref, guv_en, pump, rate, spien, ready;
	logic [5:0] ds;
	logic [2:0] hi_req, lo_req, cfg_addr, hi_out, lo_out, dt, thr, gain;
	pdfs_byte_t cfg_wdata, cfg_rdata, cur;
	pdfs_code_t fault_code;
	pdfs_row_t r;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	pdfs_byte_t defs [6] = '{8'h00, 8'h00, 8'h7c, 8'ha6, 8'he0, 8'hc0};
	// cfg4, en, vcc, mov, rov, guv, ds, off, code
	pdfs_row_t rows [12] = '{
		'{8'he0, 0, 1, 0, 0, 0, 6'h00, 1, 4'h0},
		'{8'he0, 1, 0, 0, 0, 0, 6'h00, 1, 4'h0},
		'{8'he0, 1, 1, 1, 0, 0, 6'h00, 1, 4'h7},
		'{8'he0, 1, 1, 0, 1, 0, 6'h00, 1, 4'h1},
		'{8'he0, 1, 1, 0, 0, 0, 6'h01, 1, 4'ha},
		'{8'he0, 1, 1, 0, 0, 0, 6'h20, 1, 4'ha},
		'{8'he0, 1, 1, 0, 0, 1, 6'h00, 0, 4'h0},
		'{8'h00, 1, 1, 1, 0, 0, 6'h00, 1, 4'h7},
		'{8'h00, 1, 1, 0, 1, 0, 6'h00, 0, 4'h1},
		'{8'h00, 1, 1, 0, 0, 0, 6'h3f, 0, 4'h0},
		'{8'h30, 1, 1, 0, 0, 0, 6'h08, 0, 4'ha},
		'{8'h34, 1, 1, 0, 0, 1, 6'h00, 0, 4'h3}
	};
	pdfs_host_model u_host (.clk(clk), .en_req(en_req), .ack_en(ack_en),
		.slow(slow), .fault_active(fault_active), .enable_pin(enable_pin),
		.fault_ack_pin(fault_ack_pin));
	pdfs_shutdown u_dut (.clk(clk), .rstn(rstn), .enable_pin(enable_pin),
		.vcc_ok_pin(vcc_ok), .motor_supply_overvolt_flag(mov),
		.regulator_overvolt_flag(rov), .gate_uv_raw(guv), .ds_comp_raw(ds),
		.fault_ack_pin(fault_ack_pin), .gate_hi_req(hi_req),
		.gate_lo_req(lo_req), .serial_mode(serial_mode), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.gate_hi_out(hi_out), .gate_lo_out(lo_out), .gates_off(gates_off),
		.fault_active(fault_active), .fault_code(fault_code),
		.dead_time_select(dt), .ds_threshold_select(thr),
		.sense_gain_select(gain), .boost_reference_select(bref),
		.gate_uv_comparator_enable(guv_en), .boost_pump_enable(pump),
		.fault_rate_fast(rate), .serial_port_enable(spien),
		.config_ready(ready));
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc_n(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc_n
	// copy takes a few cycles; give it a bounded wait
	task automatic wait_ready();
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			cyc_n(1);
			n++;
		end
		chk("config_ready", 1, ready);
	endtask : wait_ready
	// host keeps acking until the latches have cleared
	task automatic ack_all();
		ack_en = 1;
		n = 0;
		while (fault_active !== 1'b0 && n < 400) begin
			cyc_n(1);
			n++;
		end
		ack_en = 0;
		cyc_n(10);
		chk("fault_code", 0, fault_code);
	endtask : ack_all
	// one write in serial mode, read back, then leave and wait for copy
	task automatic prog(input logic [2:0] a, input pdfs_byte_t d,
		input pdfs_byte_t rd);
		en_req = 0;
		serial_mode = 1;
		cyc_n(2);
		cfg_wr = 1;
		cfg_addr = a;
		cfg_wdata = d;
		cyc_n(1);
		cfg_wr = 0;
		cyc_n(2);
		if (a < 6 && spien === 1'b1) chk("cfg_rdata", rd, cfg_rdata);
		serial_mode = 0;
		en_req = 1;
		cyc_n(4);
		chk("gates_off", 1, gates_off);
		wait_ready();
	endtask : prog
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		{rstn, ack_en, slow, mov, rov, guv, ds, hi_req, lo_req} = '0;
		{serial_mode, cfg_wr, cfg_addr, cfg_wdata} = '0;
		en_req = 1;
		vcc_ok = 1;
		cyc_n(20);
		chk("gates_off", 1, gates_off);
		rstn = 1;
		cyc_n(3);
		chk("gates_off", 1, gates_off);
		wait_ready();
		chk("dt", 3, dt);
		chk("thr", 7, thr);
		chk("gain", 3, gain);
		chk("bref", 0, bref);
		chk("spien", 1, spien);
		chk("guv_en", 0, guv_en);
		chk("rate", 1, rate);
		chk("pump", 0, pump);
		en_req = 0;
		serial_mode = 1;
		for (int a = 0; a < 6; a++) begin
			cfg_addr = a[2:0];
			cyc_n(2);
			chk("default byte", defs[a], cfg_rdata);
		end
		serial_mode = 0;
		en_req = 1;
		wait_ready();
		// all low sides requested so a disable shows on the gate pins
		lo_req = 3'b111;
		cur = 8'he0;
		foreach (rows[i]) begin
			r = rows[i];
			if (r.cfg4 !== cur) begin
				prog(3'h4, r.cfg4, r.cfg4);
				cur = r.cfg4;
				chk("guv_en", r.cfg4[4], guv_en);
				chk("pump", r.cfg4[2], pump);
			end
			cyc_n(100);
			slow = i[0];
			{en_req, vcc_ok, mov, rov, guv, ds} =
				{r.en, r.vcc, r.mov, r.rov, r.guv, r.ds};
			cyc_n(20);
			chk("gates_off", r.off, gates_off);
			chk("lo_out", r.off ? 8'h00 : 8'h07, lo_out);
			chk("fault_active", r.code != 0, fault_active);
			chk("fault_code", r.code, fault_code);
			{en_req, vcc_ok, mov, rov, guv, ds} = 11'h600;
			cyc_n(20);
			chk("held", r.off && r.code != 0, gates_off);
			ack_all();
			chk("gates_off", 0, gates_off);
		end
		prog(3'h2, 8'h8a, 8'h8a);
		chk("dt", 4, dt);
		chk("thr", 2, thr);
		chk("bref", 1, bref);
		prog(3'h3, 8'h4c, 8'h4c);
		chk("gain", 6, gain);
		chk("rate", 0, rate);
		prog(3'h0, 8'hff, 8'hff);
		prog(3'h6, 8'h11, 8'h00);
		chk("dt", 4, dt);
		// gap of (4 + 1) * 5 cycles between low side off and high side on
		cyc_n(100);
		lo_req = 0;
		hi_req = 3'b001;
		n = 0;
		while (lo_out[0] !== 1'b0 && n < 20) begin
			cyc_n(1);
			n++;
		end
		n = 0;
		while (hi_out[0] !== 1'b1 && n < 80) begin
			cyc_n(1);
			n++;
		end
		chk("dead time", n >= 24 && n <= 27, 1);
		// blanking code 01 hides a comparator hit for 40 cycles
		ds = 6'h01;
		cyc_n(20);
		chk("blanked", 0, fault_active);
		cyc_n(30);
		chk("fault_code", 8'h0a, fault_code);
		ds = 6'h00;
		mov = 1;
		cyc_n(20);
		chk("hi_out", 0, hi_out);
		mov = 0;
		ack_all();
		prog(3'h5, 8'h40, 8'h40);
		chk("spien", 0, spien);
		prog(3'h5, 8'hc0, 8'h00);
		chk("spien", 0, spien);
		report_and_stop();
	end
endmodule : test_pdfs_shutdown
